// file: logic/frd_ring_dma.sv
// What this block does
// R1: Ring buffer lives in page from upper bits.
// R2: Four byte FIFO between controller and memory.
// R3: One byte per word, top byte lane.
// R4: Word index steps after every word moved.
// R5: Nothing moves while transfer gate is clear.
// R6: Ring condition at index 0x3FF or 0x1FF.
// R7: Forward ring interrupt when allowed and masked in.
// R8: Pending clears on allow-zero write off marks.
// R9: Direction bits choose to or from memory.
// R10: Software never sets both direction bits.
// R11: No byte count; keep FIFO full or empty.
// R12: Slave read of FIFO port pops a byte.
// R13: Slave FIFO writes only in from-memory direction.
// R14: Controller request moves one byte with FIFO.
// R15: Controller interrupt passes only when allowed.
// R16: Status shows full, empty, pending ring interrupt.
// R17: Head pointer: gate read-only, bit one zero.
// R18: Alias: only the gate is writable.
// R19: Byte access passes through to controller registers.
// R20: Software refills half page per rollover.
// R21: Controller runs in its DMA mode.
// R22: Reset clears gate, directions, allows, FIFO.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module frd_ring_dma (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	input wire logic ring_mask_en,
	output logic ring_irq,
	output logic ctrl_irq,
	input wire logic dcc_dreq,
	input wire logic dcc_irq,
	output logic dcc_dack_n,
	output logic dcc_cs_n,
	output logic dcc_rd_n,
	output logic dcc_wr_n,
	output logic [5:0] dcc_addr,
	input wire logic [7:0] dcc_data_in,
	output logic [7:0] dcc_data_out,
	output logic dcc_data_oe_n
);
	import frd_pkg::*;

	logic [1:0] dreq_sync_q;
	logic [1:0] irq_sync_q;
	logic [7:0] din_meta_q;
	logic [7:0] din_sync_q;
	logic dreq_s;
	logic irq_s;
	logic ap;
	logic ap_ext;
	logic [15:0] ap_addr;
	logic dp_wr_q;
	logic [15:0] dp_addr_q;
	logic slv_pend_q;
	logic slv_read_q;
	logic [5:0] slv_reg_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic hresp_q;
	logic [3:0] ctrl_q;
	logic transfer_gate_q;
	logic [19:0] page_q;
	logic [9:0] ring_index_q;
	logic ring_pend_q;
	logic ring_cond;
	logic ring_clr;
	logic ring_irq_q;
	logic ctrl_irq_q;
	logic wr_hp;
	logic wr_alias;
	logic wr_ctrl;
	logic from_mem;
	logic to_mem;
	logic mem_req_q;
	logic mem_we_q;
	logic [31:0] mem_addr_q;
	logic [31:0] mem_wdata_q;
	logic mem_issue_wr;
	logic mem_issue_rd;
	frd_ext_state_type ex_state_q;
	logic [2:0] ex_cnt_q;
	logic ex_dma_q;
	logic ex_read_q;
	logic ex_done;
	logic start_slv;
	logic start_dma;
	logic dma_go;
	logic dcc_dack_n_q;
	logic dcc_cs_n_q;
	logic dcc_rd_n_q;
	logic dcc_wr_n_q;
	logic [5:0] dcc_addr_q;
	logic [7:0] dcc_data_out_q;
	logic dcc_data_oe_n_q;
	logic fifo_push;
	logic [7:0] fifo_push_data;
	logic fifo_pop;
	logic [7:0] fifo_head;
	logic fifo_full;
	logic fifo_empty;
	logic [2:0] fifo_count;
	logic disk_push;
	logic mem_push;
	logic slv_push;
	logic wr_fifo_ok;
	logic disk_pop;
	logic slv_pop;
	logic [31:0] rd_mux;

	// ==========================================================
	// Pin synchronisers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dreq_sync_q <= 2'h0;
			irq_sync_q <= 2'h0;
			din_meta_q <= 8'h00;
			din_sync_q <= 8'h00;
		end else begin
			dreq_sync_q <= {dreq_sync_q[0], dcc_dreq};
			irq_sync_q <= {irq_sync_q[0], dcc_irq};
			din_meta_q <= dcc_data_in;
			din_sync_q <= din_meta_q;
		end
	end
	assign dreq_s = dreq_sync_q[1];
	assign irq_s = irq_sync_q[1];

	// ==========================================================
	// Bus slave decode.
	assign ap = hsel && htrans[1] && hready;
	assign ap_addr = haddr[15:0];
	assign ap_ext = (ap_addr == OFF_DCC_DATA) || (ap_addr == OFF_DCC_MSTAT) ||
		(ap_addr == OFF_DCC_CTRL) || (ap_addr == OFF_DCC_OPS);
	assign from_mem = ctrl_q[CTL_FROM_MEM];
	assign to_mem = ctrl_q[CTL_TO_MEM];
	assign wr_hp = dp_wr_q && (dp_addr_q == OFF_HEAD_PTR);
	assign wr_alias = dp_wr_q && (dp_addr_q == OFF_ENA_ALIAS);
	assign wr_ctrl = dp_wr_q && (dp_addr_q == OFF_CONTROL);

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (ap_addr)
			OFF_FIFO_PORT: rd_mux = {24'h000000, fifo_head};
			OFF_CONTROL: rd_mux = {28'h0000000, ctrl_q};
			OFF_STATUS: rd_mux = {29'h00000000, ring_pend_q, fifo_empty, fifo_full}; // [R16]
			OFF_HEAD_PTR, OFF_ENA_ALIAS: rd_mux = {page_q, ring_index_q, 1'b0, transfer_gate_q}; // [R17] [R18]
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 16'h0000;
			slv_pend_q <= 1'b0;
			slv_read_q <= 1'b0;
			slv_reg_q <= 6'h00;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h00000000;
			hresp_q <= 1'b0;
		end else begin
			dp_wr_q <= ap && hwrite && !ap_ext;
			if (ap) begin
				dp_addr_q <= ap_addr;
			end
			if (ap && ap_ext) begin
				slv_pend_q <= 1'b1; // [R19]
				slv_read_q <= !hwrite;
				slv_reg_q <= ap_addr[7:2];
				hreadyout_q <= 1'b0;
			end else begin
				if (start_slv) begin
					slv_pend_q <= 1'b0;
				end
				if (ex_done && !ex_dma_q) begin
					hreadyout_q <= 1'b1;
					hrdata_q <= {24'h000000, din_sync_q};
				end
			end
			if (ap && !hwrite && !ap_ext) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	// ==========================================================
	// Control, head pointer and gate.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RST; // [R22]
			transfer_gate_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= hwdata[3:0]; // [R9]
			end
			if (wr_alias) begin
				transfer_gate_q <= hwdata[HP_GATE]; // [R18]
			end
		end
	end

	// Software writes win over a step in the same cycle so a rewind is never half lost.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			page_q <= PAGE_RST;
			ring_index_q <= IDX_RST;
		end else if (wr_hp) begin
			page_q <= hwdata[31:PAGE_LSB]; // [R17]
			ring_index_q <= hwdata[IDX_MSB:IDX_LSB];
		end else if (mem_req_q && mem_ack) begin
			ring_index_q <= ring_index_q + 10'h001; // [R4]
		end
	end

	// ==========================================================
	// Ring and controller interrupts.
	assign ring_cond = (ring_index_q == IDX_PAGE_END) || (ring_index_q == IDX_HALF_END); // [R6]
	assign ring_clr = wr_ctrl && !hwdata[CTL_RING_IE] && !ring_cond; // [R8]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ring_pend_q <= 1'b0;
			ring_irq_q <= 1'b0;
			ctrl_irq_q <= 1'b0;
		end else begin
			if (ring_cond) begin
				ring_pend_q <= 1'b1;
			end else if (ring_clr) begin
				ring_pend_q <= 1'b0; // [R8]
			end
			ring_irq_q <= ring_pend_q && ctrl_q[CTL_RING_IE] && ring_mask_en; // [R7]
			ctrl_irq_q <= irq_s && ctrl_q[CTL_CTRL_IE]; // [R15]
		end
	end

	// ==========================================================
	// Memory side: one word in flight, no byte count.
	assign mem_issue_wr = !mem_req_q && transfer_gate_q && to_mem && !from_mem && !fifo_empty; // [R5] [R11]
	assign mem_issue_rd = !mem_req_q && transfer_gate_q && from_mem && !to_mem && !fifo_full; // [R5] [R11]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= 32'h00000000;
			mem_wdata_q <= 32'h00000000;
		end else if (mem_req_q) begin
			if (mem_ack) begin
				mem_req_q <= 1'b0;
			end
		end else if (mem_issue_wr || mem_issue_rd) begin
			mem_req_q <= 1'b1;
			mem_we_q <= mem_issue_wr; // [R9]
			mem_addr_q <= {page_q, ring_index_q, 2'b00}; // [R1]
			mem_wdata_q <= {fifo_head, 24'h000000}; // [R3]
		end
	end

	// ==========================================================
	// Controller side: shared cycle engine for slave access and DMA bytes.
	assign dma_go = transfer_gate_q && dreq_s && (to_mem != from_mem) &&
		((to_mem && !fifo_full) || (from_mem && !fifo_empty)); // [R14]
	assign start_slv = (ex_state_q == EX_IDLE) && slv_pend_q;
	assign start_dma = (ex_state_q == EX_IDLE) && !slv_pend_q && dma_go;
	assign ex_done = (ex_state_q == EX_STROBE) && (ex_cnt_q == 3'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ex_state_q <= EX_IDLE;
			ex_cnt_q <= 3'h0;
			ex_dma_q <= 1'b0;
			ex_read_q <= 1'b0;
			dcc_dack_n_q <= 1'b1;
			dcc_cs_n_q <= 1'b1;
			dcc_rd_n_q <= 1'b1;
			dcc_wr_n_q <= 1'b1;
			dcc_addr_q <= 6'h00;
			dcc_data_out_q <= 8'h00;
			dcc_data_oe_n_q <= 1'b1;
		end else begin
			unique case (ex_state_q)
				EX_IDLE: begin
					if (start_slv) begin
						ex_dma_q <= 1'b0;
						ex_read_q <= slv_read_q;
						dcc_cs_n_q <= 1'b0; // [R19]
						dcc_addr_q <= slv_reg_q;
						dcc_data_out_q <= hwdata[7:0];
						dcc_data_oe_n_q <= slv_read_q;
						ex_state_q <= EX_SETUP;
					end else if (start_dma) begin
						ex_dma_q <= 1'b1;
						ex_read_q <= to_mem;
						dcc_dack_n_q <= 1'b0; // [R14]
						dcc_data_out_q <= fifo_head;
						dcc_data_oe_n_q <= to_mem;
						ex_state_q <= EX_SETUP;
					end
				end
				EX_SETUP: begin
					dcc_rd_n_q <= !ex_read_q;
					dcc_wr_n_q <= ex_read_q;
					ex_cnt_q <= STROBE_CYC - 3'h1;
					ex_state_q <= EX_STROBE;
				end
				EX_STROBE: begin
					if (ex_cnt_q == 3'h0) begin
						dcc_rd_n_q <= 1'b1;
						dcc_wr_n_q <= 1'b1;
						ex_cnt_q <= RECOVER_CYC - 3'h1;
						ex_state_q <= EX_RECOVER;
					end else begin
						ex_cnt_q <= ex_cnt_q - 3'h1;
					end
				end
				EX_RECOVER: begin
					// Request stays masked until the synchroniser has seen it drop.
					if (ex_cnt_q == 3'h0) begin
						dcc_dack_n_q <= 1'b1;
						dcc_cs_n_q <= 1'b1;
						dcc_data_oe_n_q <= 1'b1;
						ex_state_q <= EX_IDLE;
					end else begin
						ex_cnt_q <= ex_cnt_q - 3'h1;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// FIFO arbitration and instance.
	assign disk_push = ex_done && ex_dma_q && ex_read_q;
	assign mem_push = mem_req_q && mem_ack && !mem_we_q;
	assign slv_push = wr_fifo_ok && !mem_push;
	assign wr_fifo_ok = dp_wr_q && (dp_addr_q == OFF_FIFO_PORT) && from_mem && !fifo_full &&
		!(mem_req_q && !mem_we_q); // [R13]
	assign disk_pop = start_dma && from_mem;
	assign slv_pop = ap && !hwrite && (ap_addr == OFF_FIFO_PORT) && !disk_pop && !mem_issue_wr; // [R12]
	assign fifo_push = disk_push || mem_push || slv_push;
	assign fifo_push_data = disk_push ? din_sync_q :
		(mem_push ? mem_rdata[31:LANE_LSB] : hwdata[7:0]); // [R3]
	assign fifo_pop = disk_pop || mem_issue_wr || slv_pop;

	frd_fifo #(
		.W(FIFO_W),
		.D(FIFO_D),
		.CW(3)
	) u_fifo ( // [R2]
		.clk(hclk),
		.rst_n(hresetn),
		.push(fifo_push),
		.push_data(fifo_push_data),
		.pop(fifo_pop),
		.head(fifo_head),
		.full(fifo_full),
		.empty(fifo_empty),
		.count(fifo_count)
	);

	// ==========================================================
	// Outputs.
	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
	assign mem_req = mem_req_q;
	assign mem_we = mem_we_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign ring_irq = ring_irq_q;
	assign ctrl_irq = ctrl_irq_q;
	assign dcc_dack_n = dcc_dack_n_q;
	assign dcc_cs_n = dcc_cs_n_q;
	assign dcc_rd_n = dcc_rd_n_q;
	assign dcc_wr_n = dcc_wr_n_q;
	assign dcc_addr = dcc_addr_q;
	assign dcc_data_out = dcc_data_out_q;
	assign dcc_data_oe_n = dcc_data_oe_n_q;

	// ==========================================================
	// Assertions.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_ext_start;
		(ex_state_q == EX_IDLE) && (start_slv || start_dma);
	endsequence
	sequence s_strobe_low;
		(!dcc_rd_n_q || !dcc_wr_n_q) [*4];
	endsequence

	chk_strobe_width: assert property (s_ext_start |=> ##1 s_strobe_low ##1 (dcc_rd_n_q && dcc_wr_n_q)) // [R14]
		else $error("controller strobe width wrong");
	chk_ring_set: assert property (ring_cond |=> ring_pend_q) // [R6]
		else $error("ring pending not set at mark");
	chk_ring_hold: assert property (ring_pend_q && !ring_clr |=> ring_pend_q) // [R8]
		else $error("ring pending cleared without allow-zero write");
	chk_ring_fwd: assert property (ring_irq_q |-> $past(ctrl_q[CTL_RING_IE]) && $past(ring_mask_en)) // [R7]
		else $error("ring interrupt forwarded while not allowed");
	chk_gate_stop: assert property ($rose(mem_req_q) |-> $past(transfer_gate_q)) // [R5]
		else $error("memory word moved with gate clear");
	chk_index_step: assert property (mem_req_q && mem_ack && !wr_hp |=>
		ring_index_q == $past(ring_index_q) + 10'h001) // [R4]
		else $error("word index did not step");
	chk_word_lane: assert property (mem_req_q && mem_we_q |-> mem_wdata_q[23:0] == 24'h000000) // [R3]
		else $error("byte not alone in top lane");
	chk_page_base: assert property (mem_req_q |-> mem_addr_q[31:12] == page_q &&
		mem_addr_q[1:0] == 2'b00) // [R1]
		else $error("memory address outside ring page");
	chk_ctrl_irq: assert property (ctrl_irq_q |-> $past(ctrl_q[CTL_CTRL_IE]) && $past(irq_s)) // [R15]
		else $error("controller interrupt passed while not allowed");
	chk_slv_push_dir: assert property (slv_push |-> from_mem) // [R13]
		else $error("slave FIFO write outside from-memory direction");
	chk_fifo_pop_read: assert property (slv_pop && !fifo_empty && !fifo_push |=>
		fifo_count == $past(fifo_count) - 3'h1) // [R12]
		else $error("FIFO read did not pop");
	chk_status_read: assert property (ap && !hwrite && ap_addr == OFF_STATUS |=>
		hrdata_q[2:0] == {$past(ring_pend_q), $past(fifo_empty), $past(fifo_full)}) // [R16]
		else $error("status bits wrong");
	chk_head_ro_bits: assert property (ap && !hwrite && ap_addr == OFF_HEAD_PTR |=>
		hrdata_q[1] == 1'b0 && hrdata_q[0] == $past(transfer_gate_q)) // [R17]
		else $error("head pointer low bits wrong");
endmodule : frd_ring_dma
`default_nettype wire

// file: logic/frd_pkg.sv
`default_nettype none
package frd_pkg;
	// ==========================================================
	// Register offsets within the 64 KB window.
	localparam logic [15:0] OFF_DCC_DATA = 16'hA004;
	localparam logic [15:0] OFF_DCC_MSTAT = 16'hA008;
	localparam logic [15:0] OFF_DCC_CTRL = 16'hA020;
	localparam logic [15:0] OFF_DCC_OPS = 16'hA040;
	localparam logic [15:0] OFF_FIFO_PORT = 16'hA014;
	localparam logic [15:0] OFF_CONTROL = 16'hA018;
	localparam logic [15:0] OFF_STATUS = 16'hA01C;
	localparam logic [15:0] OFF_HEAD_PTR = 16'hD000;
	localparam logic [15:0] OFF_ENA_ALIAS = 16'hD004;
	// ==========================================================
	// Field positions.
	localparam int CTL_FROM_MEM = 0;
	localparam int CTL_TO_MEM = 1;
	localparam int CTL_CTRL_IE = 2;
	localparam int CTL_RING_IE = 3;
	localparam int STAT_FULL = 0;
	localparam int STAT_EMPTY = 1;
	localparam int STAT_RING = 2;
	localparam int HP_GATE = 0;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 11;
	localparam int PAGE_LSB = 12;
	localparam int LANE_LSB = 24;
	// ==========================================================
	// Values after reset and ring marks.
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [19:0] PAGE_RST = 20'h00000;
	localparam logic [9:0] IDX_RST = 10'h000;
	localparam logic [9:0] IDX_PAGE_END = 10'h3FF;
	localparam logic [9:0] IDX_HALF_END = 10'h1FF;
	// ==========================================================
	// FIFO shape and external cycle timing.
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 4;
	localparam int CLK_NS = 100;
	localparam int STROBE_NS = 400;
	localparam int RECOVER_NS = 300;
	localparam logic [2:0] STROBE_CYC = 3'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [2:0] RECOVER_CYC = 3'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [1:0] {EX_IDLE, EX_SETUP, EX_STROBE, EX_RECOVER} frd_ext_state_type;
endpackage : frd_pkg
`default_nettype wire

// file: logic/frd_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module frd_fifo #(
	parameter int W = 8,
	parameter int D = 4,
	parameter int CW = $clog2(D + 1)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [W-1:0] push_data,
	input wire logic pop,
	output logic [W-1:0] head,
	output logic full,
	output logic empty,
	output logic [CW-1:0] count
);
	localparam int AW = $clog2(D);
	localparam logic [AW-1:0] LAST = AW'(D - 1);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [CW-1:0] count_q;
	logic do_push;
	logic do_pop;

	// ==========================================================
	// Pointers and occupancy; a push when full or a pop when empty is dropped.
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign full = (count_q == CW'(D));
	assign empty = (count_q == '0);
	assign head = mem_q[rptr_q];
	assign count = count_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end else begin
			if (do_push) begin
				wptr_q <= (wptr_q == LAST) ? '0 : wptr_q + AW'(1);
			end
			if (do_pop) begin
				rptr_q <= (rptr_q == LAST) ? '0 : rptr_q + AW'(1);
			end
			if (do_push && !do_pop) begin
				count_q <= count_q + CW'(1);
			end else if (do_pop && !do_push) begin
				count_q <= count_q - CW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_q[wptr_q] <= push_data;
		end
	end
endmodule : frd_fifo
`default_nettype wire

// file: sim/frd_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Host memory and disk controller chip stand-in.
module frd_partner (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	input wire logic [2:0] mem_lat,
	input wire logic [3:0] dreq_num,
	output logic dcc_dreq,
	input wire logic dcc_dack_n,
	input wire logic dcc_cs_n,
	input wire logic dcc_rd_n,
	input wire logic dcc_wr_n,
	input wire logic [5:0] dcc_addr,
	input wire logic [7:0] dcc_data_out,
	input wire logic dcc_data_oe_n,
	output logic [7:0] dcc_data_in
);
	logic [2:0] wait_q;
	logic [7:0] last_q;
	logic [7:0] out_q;
	logic [5:0] addr_q;
	logic rd_q;
	logic wr_q;
	int n_ack;
	int n_str;
	logic [31:0] wa_q [0:7];
	logic [31:0] wd_q [0:7];
	// Outside an answer the word is inverted so a stale capture shows up.
	assign mem_rdata = mem_ack ? {mem_addr[9:2], 24'hA5A5A5} : {~mem_addr[9:2], 24'h5A5A5A};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_ack <= 1'b0;
			wait_q <= 3'h0;
			n_ack <= 0;
		end else if (mem_req && !mem_ack && wait_q >= mem_lat) begin
			mem_ack <= 1'b1;
			wait_q <= 3'h0;
			n_ack <= n_ack + 1;
			wa_q[n_ack[2:0]] <= mem_addr;
			// A word taken without the write flag is kept inverted so the bench sees it.
			wd_q[n_ack[2:0]] <= mem_we ? mem_wdata : ~mem_wdata;
		end else begin
			mem_ack <= 1'b0;
			if (mem_req && !mem_ack) wait_q <= wait_q + 3'h1;
		end
	end
	// ==========================================================
	// Disk side: one request per byte until the wanted count is met.
	assign dcc_dreq = n_str < int'(dreq_num);
	assign dcc_data_in = (!dcc_rd_n && !dcc_dack_n) ? 8'hC0 + 8'(n_str) :
		(!dcc_rd_n && !dcc_cs_n) ? 8'h5C : ~last_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b1;
			wr_q <= 1'b1;
			n_str <= 0;
			last_q <= 8'h00;
		end else begin
			rd_q <= dcc_rd_n;
			wr_q <= dcc_wr_n;
			last_q <= dcc_data_in;
			if ((dcc_rd_n && !rd_q) || (dcc_wr_n && !wr_q)) begin
				addr_q <= dcc_addr;
				out_q <= dcc_data_oe_n ? ~dcc_data_out : dcc_data_out;
				if (!dcc_dack_n) n_str <= n_str + 1;
			end
		end
	end
endmodule : frd_partner
`default_nettype wire

// file: sim/floppy_ring_dma_tb.sv
`timescale 1ns/100ps
`default_nettype none
module floppy_ring_dma_tb;
	import frd_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ring_mask_en, ring_irq;
	logic ctrl_irq, mem_req, mem_we, mem_ack, dcc_dreq, dcc_irq, dcc_dack_n, dcc_cs_n;
	logic dcc_rd_n, dcc_wr_n, dcc_data_oe_n;
	logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, mem_lat;
	logic [3:0] dreq_num;
	logic [5:0] dcc_addr;
	logic [7:0] dcc_data_in, dcc_data_out;
	int n_fail, tests_run;
	assign hready = hreadyout;
	frd_ring_dma i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hrdata, .hresp, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .ring_mask_en, .ring_irq, .ctrl_irq, .dcc_dreq, .dcc_irq,
		.dcc_dack_n, .dcc_cs_n, .dcc_rd_n, .dcc_wr_n, .dcc_addr, .dcc_data_in,
		.dcc_data_out, .dcc_data_oe_n);
	frd_partner i_part (.hclk, .hresetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_ack, .mem_lat, .dreq_num, .dcc_dreq, .dcc_dack_n, .dcc_cs_n, .dcc_rd_n,
		.dcc_wr_n, .dcc_addr, .dcc_data_out, .dcc_data_oe_n, .dcc_data_in);
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// ==========================================================
	// Shared tasks.
	task stop_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task ahb(input logic w, input logic [15:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {16'h0000, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : ahb
	task wr(input logic [15:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask : wr
	task rdc(input logic [15:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	// Bounded wait on the partner's strobe or acknowledge count.
	task wait_cnt(input logic s, input int n);
		int k;
		k = 0;
		while (k < 400 && (s ? i_part.n_str : i_part.n_ack) < n) begin
			@(posedge hclk);
			k++;
		end
		if (k >= 400) chk(32'(k), 32'h0);
	endtask : wait_cnt
	// ==========================================================
	// Scenarios. Direction bits are set one at a time.
	task t_regs;
		rdc(OFF_CONTROL, 32'h0);
		rdc(OFF_STATUS, 32'h2);
		rdc(OFF_HEAD_PTR, 32'h0);
		rdc(16'hA030, 32'h0);
		wr(OFF_HEAD_PTR, 32'h12345FFF);
		rdc(OFF_HEAD_PTR, 32'h12345FFC);
		wr(OFF_ENA_ALIAS, 32'hFFFFF001);
		rdc(OFF_ENA_ALIAS, 32'h12345FFD);
		cyc(10);
		chk(32'(i_part.n_ack), 32'h0);
		wr(OFF_ENA_ALIAS, 32'h0);
	endtask : t_regs
	task t_ring;
		for (int i = 0; i < 2; i++) begin
			wr(OFF_HEAD_PTR, {20'h00030, (i == 0) ? IDX_HALF_END : IDX_PAGE_END, 2'b00});
			wr(OFF_CONTROL, 32'h8);
			ring_mask_en <= 1'b1;
			cyc(4);
			chk(ring_irq, 1'b1);
			rdc(OFF_STATUS, 32'h6);
			ring_mask_en <= 1'b0;
			cyc(4);
			chk(ring_irq, 1'b0);
			wr(OFF_CONTROL, 32'h0);
			rdc(OFF_STATUS, 32'h6);
			wr(OFF_HEAD_PTR, 32'h00030014);
			rdc(OFF_STATUS, 32'h6);
			wr(OFF_CONTROL, 32'h0);
			rdc(OFF_STATUS, 32'h2);
		end
	endtask : t_ring
	// Three bytes to memory across the page end, with a slow memory.
	// The rollover is serviced before the next run, as software must.
	task t_to_mem;
		logic [31:0] ea [0:2];
		ea = '{32'h00010FF8, 32'h00010FFC, 32'h00010000};
		mem_lat <= 3'h4;
		wr(OFF_HEAD_PTR, 32'h00010FF8);
		wr(OFF_CONTROL, 32'h2);
		wr(OFF_ENA_ALIAS, 32'h1);
		dreq_num <= 4'h3;
		wait_cnt(1'b0, 3);
		for (int k = 0; k < 3; k++) begin
			chk(i_part.wa_q[k], ea[k]);
			chk(i_part.wd_q[k], {8'hC0 + 8'(k), 24'h0});
		end
		wr(OFF_ENA_ALIAS, 32'h0);
		rdc(OFF_HEAD_PTR, 32'h00010004);
		rdc(OFF_STATUS, 32'h6);
		wr(OFF_CONTROL, 32'h0);
		rdc(OFF_STATUS, 32'h2);
	endtask : t_to_mem
	// From memory: the FIFO fills to four and stops, one byte goes out.
	task t_from_mem;
		mem_lat <= 3'h1;
		wr(OFF_HEAD_PTR, 32'h00020040);
		wr(OFF_CONTROL, 32'h1);
		wr(OFF_ENA_ALIAS, 32'h1);
		wait_cnt(1'b0, 7);
		cyc(10);
		chk(32'(i_part.n_ack), 32'h7);
		rdc(OFF_STATUS, 32'h1);
		dreq_num <= 4'h4;
		wait_cnt(1'b1, 4);
		chk(i_part.out_q, 8'h10);
		wait_cnt(1'b0, 8);
		wr(OFF_ENA_ALIAS, 32'h0);
		for (int k = 0; k < 4; k++) rdc(OFF_FIFO_PORT, 32'h11 + k);
		rdc(OFF_STATUS, 32'h2);
		rdc(OFF_HEAD_PTR, 32'h00020054);
		wr(OFF_FIFO_PORT, 32'h77);
		rdc(OFF_STATUS, 32'h0);
		rdc(OFF_FIFO_PORT, 32'h77);
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_FIFO_PORT, 32'h88);
		rdc(OFF_STATUS, 32'h2);
	endtask : t_from_mem
	task t_ext;
		rdc(OFF_DCC_MSTAT, 32'h5C);
		cyc(1);
		chk(i_part.addr_q, 6'h02);
		wr(OFF_DCC_CTRL, 32'h3C);
		cyc(1);
		chk(i_part.out_q, 8'h3C);
		chk(i_part.addr_q, 6'h08);
		dcc_irq <= 1'b1;
		cyc(6);
		chk(ctrl_irq, 1'b0);
		wr(OFF_CONTROL, 32'h4);
		cyc(5);
		chk(ctrl_irq, 1'b1);
		dcc_irq <= 1'b0;
		cyc(5);
		chk(ctrl_irq, 1'b0);
	endtask : t_ext
	// ==========================================================
	// Main sequence and watchdog.
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		ring_mask_en = 1'b0;
		dcc_irq = 1'b0;
		mem_lat = 3'h1;
		dreq_num = 4'h0;
		n_fail = 0;
		tests_run = 0;
		cyc(10);
		hresetn <= 1'b1;
		cyc(1);
		t_regs;
		t_ring;
		t_to_mem;
		t_from_mem;
		t_ext;
		stop_test;
	end
	initial begin
		#(100 * 20000);
		n_fail++;
		stop_test;
	end
endmodule : floppy_ring_dma_tb
`default_nettype wire
